/* File: src/ident_feat_words.sv */
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// How it works
// RULE1 - SATA enabled word: bit0 clear, enables only
// RULE2 - Supported words two, three carry 01 mark
// RULE3 - Host ignores all-zero or all-ones supported words
// RULE4 - Reserved bits of supported words read zero
// RULE5 - Unsupported feature bits of first word zero
// RULE6 - Power, buffer, NOP bits always one
// RULE7 - Security, cache, look-ahead, APM from capability
// RULE8 - Microcode, queued, CFA, media status zero
// RULE9 - Enabled words reserved, third carries 01 mark
// RULE10 - Enabled security, cache, look-ahead reported live
// RULE11 - Enabled first word fixed bits mirror supported
// RULE12 - APM enabled bit three, others zero
// RULE13 - One DMA mode selected, kinds exclusive
// RULE14 - Ultra select bits 8 to 14
// RULE15 - Ultra support bits cumulative below top
// RULE16 - No Ultra DMA gives zero word
// RULE17 - Erase time word is half minutes
// RULE18 - Master revision code reported, else zero
// RULE19 - Level bit only when enabled at maximum
// RULE20 - Expired count aborts unlock, erase until reset
// RULE21 - Security status bits follow state
// RULE22 - Variable bits from live state at read
module ident_feat_words #(
  parameter int          ADDR_W = 8,
  parameter logic [3:0]  TRIES  = ident_feat_pkg::UNLOCK_TRIES
) (
  input  wire logic              sys_clk_in,
  input  wire logic              srst_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic [6:0]             udma_sel_out,
  output logic [2:0]             mdma_sel_out,
  output logic                   sec_expired_out,
  output logic                   sec_cmd_abort_out
);

  // ==========================================================================
  // Helpers
  function automatic logic [6:0] cum_mask(input logic [2:0] top);
    logic [6:0] m;
    m = 7'h00;
    for (int i = 0; i < 7; i++) begin
      if (3'(i) <= top) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : cum_mask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Selections beyond the live capability are hidden from udma_sel_out, not forgotten
  function automatic logic [6:0] gated_udma(input logic [6:0] sel, input logic [2:0] top,
                                            input logic sup);
    return sel & cum_mask(top) & {7{sup}};
  endfunction : gated_udma

  // ==========================================================================
  // Storage
  logic [31:0] cap_ff;
  logic [31:0] ena_ff;
  logic [3:0]  sec_ff;
  logic [15:0] erase_ff;
  logic [15:0] mpw_ff;
  logic [3:0]  tries_ff;
  logic        expired_ff;
  logic        abort_ff;
  logic [6:0]  udma_ff;
  logic [2:0]  mdma_ff;
  logic [31:0] rdata_ff;
  logic        ready_ff;
  logic        err_ff;

  // ==========================================================================
  // Live decode of configuration
  logic        sec_sup;
  logic        wc_sup;
  logic        la_sup;
  logic        apm_sup;
  logic        enh_sup;
  logic        udma_sup;
  logic [2:0]  udma_max;
  logic [5:0]  sata_sup;
  logic        sec_en;
  logic [15:0] w79;
  logic [15:0] w82;
  logic [15:0] w83;
  logic [15:0] w84;
  logic [15:0] w85;
  logic [15:0] w86;
  logic [15:0] w87;
  logic [15:0] w88;
  logic [15:0] w89;
  logic [15:0] w92;
  logic [15:0] w128;
  logic [16:0] erase_sum;

  always_comb begin
    sec_sup  = cap_ff[ident_feat_pkg::CAP_SEC_BIT];
    wc_sup   = cap_ff[ident_feat_pkg::CAP_WC_BIT];
    la_sup   = cap_ff[ident_feat_pkg::CAP_LA_BIT];
    apm_sup  = cap_ff[ident_feat_pkg::CAP_APM_BIT];
    enh_sup  = cap_ff[ident_feat_pkg::CAP_ENH_BIT];
    udma_sup = cap_ff[ident_feat_pkg::CAP_UDMA_BIT];
    udma_max = cap_ff[ident_feat_pkg::CAP_UMAX_LSB +: 3];
    // Modes above the top mode are clamped rather than rejected
    if (udma_max > ident_feat_pkg::UDMA_TOP) begin
      udma_max = ident_feat_pkg::UDMA_TOP;
    end
    sata_sup = cap_ff[ident_feat_pkg::CAP_SATA_LSB +: 6];
    sec_en   = sec_sup & sec_ff[ident_feat_pkg::SEC_EN_BIT];
  end

  // ==========================================================================
  // Identify words, rebuilt every cycle from current state
  always_comb begin
    // An enable without the matching support never shows
    w79 = {9'h000, ena_ff[ident_feat_pkg::ENA_SATA_LSB +: 6] & sata_sup, 1'b0}; // RULE1 RULE22
    w82 = {1'b0, 3'b111, 1'b0, 4'b0000, la_sup, wc_sup, 1'b0, 1'b1,  // RULE5 RULE6 RULE7
           1'b0, sec_sup, 1'b0};                                    // RULE5 RULE7
    w83 = {2'b01, 10'h000, apm_sup, 3'b000};                         // RULE2 RULE4 RULE7 RULE8
    // Never all zeros nor all ones, so the host decodes the bits
    w84 = ident_feat_pkg::VALID_WORD;                                // RULE2 RULE3 RULE4
    w85 = {1'b0, 3'b111, 1'b0, 4'b0000,                              // RULE11
           la_sup & ena_ff[ident_feat_pkg::ENA_LA_BIT],              // RULE10
           wc_sup & ena_ff[ident_feat_pkg::ENA_WC_BIT],              // RULE10
           1'b0, 1'b1, 1'b0, sec_en, 1'b0};                          // RULE10 RULE11
    w86 = {12'h000, apm_sup & ena_ff[ident_feat_pkg::ENA_APM_BIT], 3'b000}; // RULE9 RULE12
    w87 = ident_feat_pkg::VALID_WORD;                                // RULE9
    if (udma_sup) begin
      w88 = {1'b0, udma_ff, 1'b0, cum_mask(udma_max)};               // RULE14 RULE15
    end else begin
      w88 = 16'h0000;                                                // RULE16
    end
    // Rounded up so the reported time never undercuts the real one
    erase_sum = {1'b0, erase_ff} + 17'h0_0001;
    w89 = sec_sup ? erase_sum[16:1] : 16'h0000;                      // RULE17
    w92 = sec_sup ? mpw_ff : 16'h0000;                               // RULE18
    if (sec_sup) begin
      w128 = {7'h00, sec_en & sec_ff[ident_feat_pkg::SEC_MAX_BIT],   // RULE19
              2'b00, enh_sup, expired_ff,                            // RULE20 RULE21
              sec_ff[ident_feat_pkg::SEC_FRZ_BIT],                   // RULE21
              sec_ff[ident_feat_pkg::SEC_LOCK_BIT], sec_en, 1'b1};   // RULE21
    end else begin
      w128 = 16'h0000;
    end
  end

  // ==========================================================================
  // APB decode
  logic [7:0]  addr;
  logic        setup_ph;
  logic        wr_done;
  logic        hit;
  logic        wr_ok;
  logic [31:0] rd_val;

  assign addr     = 8'(paddr_in);
  assign setup_ph = psel_in & ~penable_in;
  assign wr_done  = psel_in & penable_in & ready_ff & pwrite_in & ~err_ff;

  always_comb begin
    hit    = 1'b1;
    wr_ok  = 1'b0;
    rd_val = 32'h0000_0000;
    case (addr)
      ident_feat_pkg::CAP_OFS: begin
        rd_val = cap_ff;
        wr_ok  = 1'b1;
      end
      ident_feat_pkg::ENA_OFS: begin
        rd_val = ena_ff;
        wr_ok  = 1'b1;
      end
      ident_feat_pkg::SEC_OFS: begin
        rd_val = {28'h000_0000, sec_ff};
        wr_ok  = 1'b1;
      end
      ident_feat_pkg::DMA_OFS: begin
        rd_val = {17'h0_0000, udma_ff, 5'h00, mdma_ff};
        wr_ok  = 1'b1;
      end
      ident_feat_pkg::ERASE_OFS: begin
        rd_val = {16'h0000, erase_ff};
        wr_ok  = 1'b1;
      end
      ident_feat_pkg::MPW_OFS: begin
        rd_val = {16'h0000, mpw_ff};
        wr_ok  = 1'b1;
      end
      ident_feat_pkg::SCMD_OFS: begin
        rd_val = {24'h00_0000, tries_ff, 1'b0, expired_ff, 1'b0, abort_ff};
        wr_ok  = 1'b1;
      end
      ident_feat_pkg::W79_OFS:  rd_val = {16'h0000, w79};
      ident_feat_pkg::W82_OFS:  rd_val = {16'h0000, w82};
      ident_feat_pkg::W83_OFS:  rd_val = {16'h0000, w83};
      ident_feat_pkg::W84_OFS:  rd_val = {16'h0000, w84};
      ident_feat_pkg::W85_OFS:  rd_val = {16'h0000, w85};
      ident_feat_pkg::W86_OFS:  rd_val = {16'h0000, w86};
      ident_feat_pkg::W87_OFS:  rd_val = {16'h0000, w87};
      ident_feat_pkg::W88_OFS:  rd_val = {16'h0000, w88};
      ident_feat_pkg::W89_OFS:  rd_val = {16'h0000, w89};
      ident_feat_pkg::W92_OFS:  rd_val = {16'h0000, w92};
      ident_feat_pkg::W128_OFS: rd_val = {16'h0000, w128};
      default:                  hit    = 1'b0;
    endcase
  end

  // ==========================================================================
  // Bus answer: data is taken in the setup cycle, so every access has
  // exactly one access cycle and a read sees the state of that moment
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else if (setup_ph) begin
      ready_ff <= 1'b1;
      err_ff   <= ~hit | (pwrite_in & ~wr_ok);
      rdata_ff <= pwrite_in ? 32'h0000_0000 : rd_val;                // RULE22
    end else begin
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cap_ff   <= ident_feat_pkg::CAP_RST;
      ena_ff   <= ident_feat_pkg::ENA_RST;
      sec_ff   <= ident_feat_pkg::SEC_RST;
      erase_ff <= ident_feat_pkg::ERASE_RST;
      mpw_ff   <= ident_feat_pkg::MPW_RST;
    end else if (wr_done) begin
      case (addr)
        ident_feat_pkg::CAP_OFS:   cap_ff   <= merge(cap_ff, pwdata_in, pstrb_in);
        ident_feat_pkg::ENA_OFS:   ena_ff   <= merge(ena_ff, pwdata_in, pstrb_in);
        ident_feat_pkg::SEC_OFS: begin
          if (pstrb_in[0]) begin
            sec_ff <= pwdata_in[3:0];
          end
        end
        ident_feat_pkg::ERASE_OFS: begin
          erase_ff <= 16'(merge({16'h0000, erase_ff}, pwdata_in, pstrb_in));
        end
        ident_feat_pkg::MPW_OFS: begin
          mpw_ff <= 16'(merge({16'h0000, mpw_ff}, pwdata_in, pstrb_in)); // RULE18
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // DMA mode selection
  logic [2:0] dma_mode;
  logic       dma_ultra;
  logic       dma_wr;

  assign dma_mode  = pwdata_in[ident_feat_pkg::DMA_MODE_LSB +: 3];
  assign dma_ultra = pwdata_in[ident_feat_pkg::DMA_ULTRA_BIT];
  assign dma_wr    = wr_done & (addr == ident_feat_pkg::DMA_OFS) & pstrb_in[0];

  // A request for a mode the drive lacks leaves the selection unchanged
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      udma_ff <= 7'h00;
      mdma_ff <= 3'h0;
    end else if (dma_wr) begin
      if (dma_ultra) begin
        if (udma_sup && dma_mode <= udma_max) begin
          udma_ff <= 7'h01 << dma_mode;                              // RULE13 RULE14
          mdma_ff <= 3'h0;                                           // RULE13
        end
      end else if (dma_mode <= {1'b0, ident_feat_pkg::MDMA_TOP}) begin
        mdma_ff <= 3'(3'h1 << dma_mode);                             // RULE13
        udma_ff <= 7'h00;                                            // RULE13
      end
    end
  end

  // ==========================================================================
  // Unlock attempt counter; only reset brings it back
  logic scmd_wr;
  logic fail_ev;
  logic guarded;

  assign scmd_wr = wr_done & (addr == ident_feat_pkg::SCMD_OFS) & pstrb_in[0];
  assign fail_ev = scmd_wr & pwdata_in[ident_feat_pkg::SCMD_FAIL_BIT];
  assign guarded = scmd_wr & (pwdata_in[ident_feat_pkg::SCMD_UNLOCK_BIT] |
                              pwdata_in[ident_feat_pkg::SCMD_ERASE_BIT]);

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      tries_ff   <= TRIES;
      expired_ff <= 1'b0;
    end else if (fail_ev && !expired_ff) begin
      if (tries_ff <= 4'h1) begin
        tries_ff   <= 4'h0;
        expired_ff <= 1'b1;                                          // RULE20
      end else begin
        tries_ff <= tries_ff - 4'h1;
      end
    end
  end

  // Verdict on the latest unlock or erase request
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      abort_ff <= 1'b0;
    end else if (guarded) begin
      abort_ff <= expired_ff | ~sec_sup;                             // RULE20
    end
  end

  // ==========================================================================
  // Output registers
  // A capability change that drops the selected ultra mode drops it here too,
  // one cycle later; the lag buys selection outputs that come from flops
  logic [6:0] udma_q_ff;
  logic [2:0] mdma_q_ff;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      udma_q_ff <= 7'h00;
    end else begin
      udma_q_ff <= gated_udma(udma_ff, udma_max, udma_sup);          // RULE13 RULE15
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      mdma_q_ff <= 3'h0;
    end else begin
      mdma_q_ff <= mdma_ff;                                          // RULE13
    end
  end

  // ==========================================================================
  // Outputs
  // Every output is a flop; ready and error stand for the access cycle only, read data holds until the next access
  assign prdata_out        = rdata_ff;
  assign pready_out        = ready_ff;
  assign pslverr_out       = err_ff;
  assign udma_sel_out      = udma_q_ff;
  assign mdma_sel_out      = mdma_q_ff;
  assign sec_expired_out   = expired_ff;                             // RULE20
  assign sec_cmd_abort_out = abort_ff;                               // RULE20

endmodule : ident_feat_words

/* File: src/ident_feat_pkg.sv */
package ident_feat_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] CAP_OFS      = 8'h00;
  localparam logic [7:0] ENA_OFS      = 8'h04;
  localparam logic [7:0] SEC_OFS      = 8'h08;
  localparam logic [7:0] DMA_OFS      = 8'h0C;
  localparam logic [7:0] ERASE_OFS    = 8'h10;
  localparam logic [7:0] MPW_OFS      = 8'h14;
  localparam logic [7:0] SCMD_OFS     = 8'h18;
  localparam logic [7:0] W79_OFS      = 8'h40;
  localparam logic [7:0] W82_OFS      = 8'h44;
  localparam logic [7:0] W83_OFS      = 8'h48;
  localparam logic [7:0] W84_OFS      = 8'h4C;
  localparam logic [7:0] W85_OFS      = 8'h50;
  localparam logic [7:0] W86_OFS      = 8'h54;
  localparam logic [7:0] W87_OFS      = 8'h58;
  localparam logic [7:0] W88_OFS      = 8'h5C;
  localparam logic [7:0] W89_OFS      = 8'h60;
  localparam logic [7:0] W92_OFS      = 8'h64;
  localparam logic [7:0] W128_OFS     = 8'h68;

  // ==========================================================================
  // Capability register fields
  localparam int CAP_SEC_BIT      = 0;
  localparam int CAP_WC_BIT       = 1;
  localparam int CAP_LA_BIT       = 2;
  localparam int CAP_APM_BIT      = 3;
  localparam int CAP_ENH_BIT      = 4;
  localparam int CAP_UDMA_BIT     = 5;
  localparam int CAP_UMAX_LSB     = 8;
  localparam int CAP_SATA_LSB     = 16;

  // Enable register fields
  localparam int ENA_WC_BIT       = 0;
  localparam int ENA_LA_BIT       = 1;
  localparam int ENA_APM_BIT      = 2;
  localparam int ENA_SATA_LSB     = 8;

  // Security state register fields
  localparam int SEC_EN_BIT       = 0;
  localparam int SEC_MAX_BIT      = 1;
  localparam int SEC_LOCK_BIT     = 2;
  localparam int SEC_FRZ_BIT      = 3;

  // DMA select register fields
  localparam int DMA_MODE_LSB     = 0;
  localparam int DMA_ULTRA_BIT    = 4;
  localparam int DMA_USEL_LSB     = 8;

  // Security command register fields
  localparam int SCMD_FAIL_BIT    = 0;
  localparam int SCMD_UNLOCK_BIT  = 1;
  localparam int SCMD_ERASE_BIT   = 2;
  localparam int SCMD_CNT_LSB     = 4;

  // ==========================================================================
  // Reset values and fixed words
  localparam logic [31:0] CAP_RST    = 32'h0000_0000;
  localparam logic [31:0] ENA_RST    = 32'h0000_0000;
  localparam logic [3:0]  SEC_RST    = 4'h0;
  localparam logic [15:0] ERASE_RST  = 16'h0000;
  localparam logic [15:0] MPW_RST    = 16'hFFFE;
  localparam logic [15:0] VALID_WORD = 16'h4000;
  localparam logic [2:0]  UDMA_TOP   = 3'h6;
  localparam logic [1:0]  MDMA_TOP   = 2'h2;
  localparam logic [3:0]  UNLOCK_TRIES = 4'h5;

endpackage : ident_feat_pkg

/* File: tb/ident_feat_props.sv */
`timescale 1ns/1ps
module ident_feat_props (
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic [6:0]  udma_sel_out,
  input wire logic [2:0]  mdma_sel_out,
  input wire logic        sec_expired_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  wire rd = pready_out && !pwrite_in;
  // ==========================================================================
  // Bus timing
  chk_ready_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  chk_stray_ready: assert property (!psel_in |=> !pready_out)
    else $error("ready without request");
  // ==========================================================================
  // Identify words and outputs
  chk_sata_fixed: assert property (rd && paddr_in == 8'h40 |-> (prdata_out & 32'hffff_ff81) == 0)
    else $error("sata word fixed bits");
  chk_sup_fixed: assert property (rd && paddr_in == 8'h44 |-> (prdata_out & 32'hffff_779d) == 32'h0000_7008)
    else $error("first supported word fixed bits");
  chk_sup_valid: assert property (rd && paddr_in == 8'h4C |-> prdata_out == 32'h0000_4000)
    else $error("third supported word");
  chk_ena_fixed: assert property (rd && paddr_in == 8'h50 |-> (prdata_out & 32'hffff_779d) == 32'h0000_7008)
    else $error("first enabled word fixed bits");
  chk_ena_valid: assert property (rd && paddr_in == 8'h58 |-> prdata_out == 32'h0000_4000)
    else $error("third enabled word");
  chk_udma_format: assert property (rd && paddr_in == 8'h5C |-> !prdata_out[15] && !prdata_out[7]
    && ((({1'b0, prdata_out[6:0]} + 8'h01) & {1'b0, prdata_out[6:0]}) == 8'h00))
    else $error("ultra dma word format");
  chk_dma_exclusive: assert property ($onehot0({udma_sel_out, mdma_sel_out}))
    else $error("more than one dma mode selected");
  chk_expired_hold: assert property (sec_expired_out |=> sec_expired_out)
    else $error("expiry cleared without reset");
  chk_reset_clear: assert property (disable iff (1'b0) srst_in |=> !sec_expired_out && udma_sel_out == 0
    && mdma_sel_out == 0) else $error("reset left state");
  cov_expired: cover property (sec_expired_out);
  cov_udma: cover property (|udma_sel_out);
  cov_mdma: cover property (|mdma_sel_out);
  cov_status: cover property (rd && paddr_in == 8'h68);
endmodule : ident_feat_props

bind ident_feat_words ident_feat_props ident_feat_props_i (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .udma_sel_out(udma_sel_out), .mdma_sel_out(mdma_sel_out), .sec_expired_out(sec_expired_out));

/* File: tb/ident_host_model.sv */
`timescale 1ns/1ps
module ident_host_model (
  input  wire logic [15:0] word_in,
  output logic             reported_out
);
  // Blank or all-ones words predate the feature bits, so nothing in them is decoded
  assign reported_out = (word_in != 16'h0000) && (word_in != 16'hffff);
endmodule : ident_host_model

/* File: tb/identify_feature_words_gen_bench.sv */
`timescale 1ns/1ps
module identify_feature_words_gen_bench;
  localparam logic [3:0] TRIES_B = 4'h3;
  logic        sys_clk_in, srst_in, psel_in, penable_in, pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, r, cap, ena, sec, erase, mpw;
  logic        pready_out, pslverr_out, sec_expired_out, sec_cmd_abort_out, e, ex, ultra, host_rep;
  logic [6:0]  udma_sel_out, usel;
  logic [2:0]  mdma_sel_out, msel, mode, mx;
  logic [15:0] host_word;
  int          mismatches, checked, seed;

  ident_feat_words #(.ADDR_W(8), .TRIES(TRIES_B)) ident_feat_words_i (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(4'hf),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .udma_sel_out(udma_sel_out), .mdma_sel_out(mdma_sel_out),
    .sec_expired_out(sec_expired_out), .sec_cmd_abort_out(sec_cmd_abort_out));
  ident_host_model ident_host_model_i (.word_in(host_word), .reported_out(host_rep));

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // Entered just after a rising edge; leaves one idle cycle so no strobe is driven twice
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic rdy;
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      rdy = pready_out;
      r = prdata_out;
      e = pslverr_out;
      n++;
    end while (rdy !== 1'b1 && n < 16);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (rdy !== 1'b1) begin
      mismatches++;
      $display("MISMATCH at %0t: no ready", $time);
      finish_test();
    end
    @(posedge sys_clk_in);
  endtask : apb

  function automatic logic [15:0] exp_word(input logic [7:0] a);
    case (a)
      8'h40: return {9'h0, ena[13:8] & cap[21:16], 1'b0};
      8'h44: return 16'h7008 | {9'h0, cap[2], cap[1], 3'h0, cap[0], 1'b0};
      8'h48: return 16'h4000 | {12'h0, cap[3], 3'h0};
      8'h50: return 16'h7008 | {9'h0, ena[1] & cap[2], ena[0] & cap[1], 3'h0, sec[0] & cap[0], 1'b0};
      8'h54: return {12'h0, ena[2] & cap[3], 3'h0};
      8'h5C: return cap[5] ? {1'b0, usel, 1'b0, 7'((8'h01 << (mx + 1)) - 1)} : 16'h0;
      8'h60: return cap[0] ? 16'((erase + 1) >> 1) : 16'h0;
      8'h64: return cap[0] ? mpw[15:0] : 16'h0;
      8'h68: return cap[0] ? {7'h0, sec[0] & sec[1], 2'h0, cap[4], ex, sec[3:2], sec[0], 1'b1} : 16'h0;
      default: return 16'h4000;
    endcase
  endfunction : exp_word

  task automatic do_reset;
    srst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    @(posedge sys_clk_in);
    {cap, ena, sec, erase, usel, msel, ex} = '0;
    mpw = 32'h0000_fffe;
  endtask : do_reset

  initial begin
    repeat (100000) @(posedge sys_clk_in);
    mismatches++;
    $display("MISMATCH at %0t: run too long", $time);
    finish_test();
  end

  initial begin
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    srst_in = 1'b1;
    host_word = 16'h0;
    mismatches = 0;
    checked = 0;
    seed = 32'hae40b5f0;
    do_reset();
    apb(0, ident_feat_pkg::CAP_OFS, 0);
    chk(r, ident_feat_pkg::CAP_RST, "capability reset");
    cap = 32'h0000_0001;
    apb(1, ident_feat_pkg::CAP_OFS, cap);
    apb(0, ident_feat_pkg::W92_OFS, 0);
    chk(r, 32'h0000_fffe, "revision reset");
    $display("reset test done");
    apb(0, 8'h30, 0);
    chk(e, 1'b1, "unmapped read error");
    chk(r, 32'h0, "unmapped read data");
    apb(1, ident_feat_pkg::W84_OFS, 32'hffff);
    chk(e, 1'b1, "identify write refused");
    $display("refusal test done");
    // Random configurations: every identify word is rebuilt from the live state
    for (int k = 0; k < 40; k++) begin
      cap = $random(seed) & 32'h003f_073f;
      apb(1, ident_feat_pkg::CAP_OFS, cap);
      ena = $random(seed) & 32'h0000_3f07;
      apb(1, ident_feat_pkg::ENA_OFS, ena);
      sec = $random(seed) & 32'h0000_000f;
      apb(1, ident_feat_pkg::SEC_OFS, sec);
      erase = $random(seed) & 32'h0000_0fff;
      apb(1, ident_feat_pkg::ERASE_OFS, erase);
      mpw = $random(seed) & 32'h0000_7fff;
      apb(1, ident_feat_pkg::MPW_OFS, mpw);
      mx = (cap[10:8] > 3'd6) ? 3'd6 : cap[10:8];
      ultra = cap[5] & $random(seed);
      mode = ultra ? 3'(($random(seed) & 32'h7) % (mx + 1)) : 3'(($random(seed) & 32'h7) % 3);
      apb(1, ident_feat_pkg::DMA_OFS, {27'h0, ultra, 1'b0, mode});
      usel = ultra ? 7'(8'h01 << mode) : 7'h0;
      msel = ultra ? 3'h0 : 3'(4'h1 << mode);
      @(posedge sys_clk_in);
      chk({udma_sel_out, mdma_sel_out}, {usel, msel}, "dma selection");
      for (int i = 0; i < 11; i++) begin
        apb(0, 8'(8'h40 + 4 * i), 0);
        chk(r, {16'h0, exp_word(8'(8'h40 + 4 * i))}, "identify word");
      end
    end
    apb(0, ident_feat_pkg::W82_OFS, 0);
    host_word <= r[15:0];
    @(posedge sys_clk_in);
    chk(host_rep, 1'b1, "host decodes supported word");
    host_word <= 16'hffff;
    @(posedge sys_clk_in);
    chk(host_rep, 1'b0, "host ignores all ones word");
    $display("random words test done");
    cap = 32'h0000_0001;
    apb(1, ident_feat_pkg::CAP_OFS, cap);
    sec = 32'h0;
    apb(1, ident_feat_pkg::SEC_OFS, sec);
    apb(1, ident_feat_pkg::SCMD_OFS, 32'h2);
    chk(sec_cmd_abort_out, 1'b0, "unlock allowed before expiry");
    for (int i = 0; i < TRIES_B; i++) begin
      chk(sec_expired_out, 1'b0, "early expiry");
      apb(1, ident_feat_pkg::SCMD_OFS, 32'h1);
    end
    ex = 1'b1;
    chk(sec_expired_out, 1'b1, "count expired");
    apb(0, ident_feat_pkg::SCMD_OFS, 0);
    chk({r[7:4], r[2]}, 5'h01, "tries left");
    apb(1, ident_feat_pkg::SCMD_OFS, 32'h2);
    chk(sec_cmd_abort_out, 1'b1, "unlock aborted");
    apb(1, ident_feat_pkg::SCMD_OFS, 32'h4);
    chk(sec_cmd_abort_out, 1'b1, "erase aborted");
    apb(0, ident_feat_pkg::W128_OFS, 0);
    chk(r, {16'h0, exp_word(8'h68)}, "status expired");
    do_reset();
    chk(sec_expired_out, 1'b0, "expiry cleared by reset");
    apb(0, ident_feat_pkg::SCMD_OFS, 0);
    chk(r[7:4], TRIES_B, "tries restored");
    $display("expiry test done");
    finish_test();
  end
endmodule : identify_feature_words_gen_bench
